// ===== hdl/mdc_pkg.sv
package mdc_pkg;
	// register addresses (4-bit select field)
	localparam logic [3:0] ADDR_VOICE_COIL_CONTROL  = 4'h1;
	localparam logic [3:0] ADDR_COMMUTATION_PRELOAD = 4'h3;
	localparam logic [3:0] ADDR_AUXILIARY_CONTROL   = 4'h7;

	// voice coil control fields
	localparam int VCC_ATTEN_LSB    = 0;
	localparam int VCC_THERMAL_BIT  = 3;
	localparam int VCC_PARK_BIT     = 4;
	localparam int VCC_SATSEEK_BIT  = 5;
	localparam int VCC_HIZ_BIT      = 6;
	localparam int VCC_PTDIS_BIT    = 7;
	localparam int VCC_LOOPBACK_BIT = 7;

	// commutation preload fields
	localparam int PRE_LOW_LSB   = 0;
	localparam int PRE_HIGH_LSB  = 3;
	localparam int PRE_CHOP_BIT  = 6;
	localparam logic [5:0] PRE_RUN_PATTERN = 6'h3F;

	// auxiliary control fields
	localparam int AUX_START_BIT   = 0;
	localparam int AUX_COIL_BIT    = 1;
	localparam int AUX_SPINDLE_BIT = 2;
	localparam int AUX_THERMAL_BIT = 3;
	localparam int AUX_TEST_BIT    = 4;
	localparam int AUX_SRESET_BIT  = 5;
	localparam int AUX_BRAKE_BIT   = 7;

	// reset values
	localparam logic       RST_PARK_REQ   = 1'b1;
	localparam logic       RST_CHOP_BLANK = 1'b1;
	localparam logic [2:0] RST_ATTEN      = 3'h0;

	// synchronised pin inputs, bit index in the sync vector
	localparam int IN_SAT_CMP  = 0;
	localparam int IN_LOOPBACK = 1;
	localparam int IN_OVERTEMP = 2;
	localparam int IN_DAC_SIGN = 3;
	localparam int IN_BLANKCMP = 4;
	localparam int IN_A_NEGX   = 5;
	localparam int IN_SPCLK    = 6;
	localparam int IN_COUNT    = 7;

	// timing
	localparam int CLK_MHZ       = 125;
	localparam int PARK_DELAY_US = 100;
	localparam int PARK_CYCLES   = PARK_DELAY_US * CLK_MHZ;
	localparam int PARK_CNT_W    = 24;
	localparam int COMM_STEPS    = 6;

	typedef enum logic [1:0] {
		MDC_BRK_IDLE,
		MDC_BRK_PARK,
		MDC_BRK_BRAKE
	} mdc_brake_e;
endpackage : mdc_pkg

// ===== hdl/mdc_regs.sv
`timescale 1ns/10ps

module mdc_regs
	import mdc_pkg::*;
#(
	parameter int PARK_DELAY_CYCLES = PARK_CYCLES
) (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst,
	// register access port
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	input  wire logic [3:0] addr,
	input  wire logic       atten_gate_in,
	input  wire logic [7:0] wr_data,
	output logic      [7:0] rd_data,
	output logic            rd_valid,
	// analog status pins
	input  wire logic       sat_comparator,
	input  wire logic       coil_loopback,
	input  wire logic       over_temperature_flag,
	input  wire logic       dac_sign,
	input  wire logic       bemf_blank_cmp,
	input  wire logic       phase_a_neg_crossing,
	input  wire logic       spindle_clock_in,
	// voice coil controls
	output logic      [2:0] atten_active,
	output logic            coil_enable,
	output logic            coil_output_hiz,
	output logic            coil_saturate,
	output logic            coil_sat_polarity,
	output logic            park_active,
	// spindle controls
	output logic      [2:0] phase_high_drive,
	output logic      [2:0] phase_low_drive,
	output logic      [2:0] commutation_counter,
	output logic            commutation_run,
	output logic            spindle_enable,
	output logic            spindle_brake,
	output logic            pwm_off_suppress,
	output logic            slew_control_off,
	output logic            single_phase_bemf,
	// misc
	output logic            test_unlock,
	output logic            soft_reset
);

	typedef struct packed {
		logic [IN_COUNT-1:0]   sync1;
		logic [IN_COUNT-1:0]   sync2;
		logic                  spclk_prev;
		logic [2:0]            atten_sel;
		logic                  atten_gate;
		logic [2:0]            atten_out;
		logic                  park_busy;
		logic [PARK_CNT_W-1:0] park_cnt;
		logic                  sat_seek;
		logic                  sat_pol;
		logic                  coil_hiz;
		logic                  park_timer_disable;
		logic [5:0]            pre_pending;
		logic [5:0]            pre_active;
		logic                  chop_blank_enable;
		logic [2:0]            comm_cnt;
		logic                  comm_run;
		logic [2:0]            hi_drv;
		logic [2:0]            lo_drv;
		logic                  pwm_supp;
		logic                  start;
		logic                  coil_en;
		logic                  spindle_en;
		logic                  test_en;
		logic                  brake_req;
		mdc_brake_e            brake_fsm;
		logic                  brake_on;
		logic                  thermal_flag;
		logic                  int_reset;
		logic [7:0]            rdata;
		logic                  rvalid;
	} mdc_state_s;

	localparam logic [PARK_CNT_W-1:0] PARK_LAST = PARK_CNT_W'(PARK_DELAY_CYCLES - 1);

	mdc_state_s s_q;
	mdc_state_s s_d;

	// bipolar commutation table: one high-side and one low-side phase per step
	// step codes 6 and 7 never occur; they leave every driver off
	function automatic logic [5:0] mdc_comm_pattern(input logic [2:0] step);
		logic [5:0] p;
		p = 6'h00;
		case (step)
			3'd0: p = {3'b001, 3'b010};
			3'd1: p = {3'b001, 3'b100};
			3'd2: p = {3'b010, 3'b100};
			3'd3: p = {3'b010, 3'b001};
			3'd4: p = {3'b100, 3'b001};
			3'd5: p = {3'b100, 3'b010};
			default: p = 6'h00;
		endcase
		return p;
	endfunction : mdc_comm_pattern

	// next-state logic for the whole bank
	always_comb begin
		logic       spclk_rise;
		logic       wr_vcc;
		logic       wr_pre;
		logic       wr_aux;
		logic       rd_vcc;
		logic       rd_aux;
		logic       braking;
		logic [5:0] drive;
		logic [2:0] want_hi;
		logic [2:0] want_lo;
		s_d = s_q;
		spclk_rise = s_q.sync2[IN_SPCLK] & ~s_q.spclk_prev;
		wr_vcc = wr_en & (addr == ADDR_VOICE_COIL_CONTROL);
		wr_pre = wr_en & (addr == ADDR_COMMUTATION_PRELOAD);
		wr_aux = wr_en & (addr == ADDR_AUXILIARY_CONTROL);
		rd_vcc = rd_en & (addr == ADDR_VOICE_COIL_CONTROL);
		rd_aux = rd_en & (addr == ADDR_AUXILIARY_CONTROL);
		braking = (s_q.brake_fsm != MDC_BRK_IDLE);
		drive = 6'h00;
		want_hi = 3'h0;
		want_lo = 3'h0;

		// two-flop synchronisers for every pin input
		// only the second stage is read, so a pin moving near the edge cannot split a decision
		s_d.sync1 = {spindle_clock_in, phase_a_neg_crossing, bemf_blank_cmp, dac_sign,
			over_temperature_flag, coil_loopback, sat_comparator};
		s_d.sync2 = s_q.sync1;
		s_d.spclk_prev = s_q.sync2[IN_SPCLK];

		// voice coil control writes; write-only selects never read back
		if (wr_vcc) begin
			s_d.atten_sel = wr_data[VCC_ATTEN_LSB +: 3];
			s_d.atten_gate = atten_gate_in;
			s_d.sat_seek = wr_data[VCC_SATSEEK_BIT];
			s_d.coil_hiz = wr_data[VCC_HIZ_BIT];
			s_d.park_timer_disable = wr_data[VCC_PTDIS_BIT];
		end
		// cascaded attenuation only while the gate is high, else full gain
		s_d.atten_out = s_q.atten_gate ? s_q.atten_sel : RST_ATTEN;
		s_d.sat_pol = s_q.sync2[IN_DAC_SIGN];

		// park delay: started by the park bit, cut short by the timer disable
		// with the timer disabled a register brake skips the park and brakes at once
		if (s_q.park_timer_disable) begin
			s_d.park_busy = 1'b0;
			s_d.park_cnt = '0;
		end else if (s_q.park_busy) begin
			if (s_q.park_cnt == PARK_LAST) begin
				s_d.park_busy = 1'b0;
				s_d.park_cnt = '0;
			end else begin
				s_d.park_cnt = s_q.park_cnt + 1'b1;
			end
		end
		if (!s_q.park_timer_disable && ((wr_vcc && wr_data[VCC_PARK_BIT] && !s_q.park_busy)
			|| (wr_aux && wr_data[AUX_BRAKE_BIT] && !braking))) begin
			s_d.park_busy = 1'b1;
			s_d.park_cnt = '0;
		end

		// preload: stored now, applied at the next spindle clock rise
		// the pending pattern is held back so a new write never reaches the drivers mid-step
		if (wr_pre) begin
			s_d.pre_pending = wr_data[5:0];
			s_d.chop_blank_enable = wr_data[PRE_CHOP_BIT];
		end
		if (spclk_rise) begin
			s_d.pre_active = s_q.pre_pending;
			s_d.comm_run = (s_q.pre_pending == PRE_RUN_PATTERN);
			if (s_q.comm_run && (s_q.pre_pending == PRE_RUN_PATTERN)) begin
				s_d.comm_cnt = (s_q.comm_cnt == 3'(COMM_STEPS - 1)) ? 3'd0 : s_q.comm_cnt + 3'd1;
			end else begin
				s_d.comm_cnt = 3'd0;
			end
		end

		// drive selection: brake shorts windings via low side, else counter or preload
		// the brake pattern overrides the counter and the preload without disturbing either
		if (s_q.brake_fsm == MDC_BRK_BRAKE) begin
			drive = {3'b000, 3'b111};
		end else if (s_q.comm_run) begin
			drive = mdc_comm_pattern(s_q.comm_cnt);
		end else if (s_q.spindle_en) begin
			drive = s_q.pre_active;
		end
		want_hi = drive[PRE_HIGH_LSB +: 3];
		want_lo = drive[PRE_LOW_LSB +: 3] & ~want_hi;
		// a phase switching sides spends one cycle with both off
		for (int i = 0; i < 3; i++) begin
			if ((s_q.hi_drv[i] && want_lo[i]) || (s_q.lo_drv[i] && want_hi[i])) begin
				s_d.hi_drv[i] = 1'b0;
				s_d.lo_drv[i] = 1'b0;
			end else begin
				s_d.hi_drv[i] = want_hi[i];
				s_d.lo_drv[i] = want_lo[i];
			end
		end
		// chop blank acts at once; it does not wait for the spindle clock
		s_d.pwm_supp = s_q.chop_blank_enable & s_q.sync2[IN_BLANKCMP] & s_q.sync2[IN_A_NEGX];

		// auxiliary control writes; spare bit 6 is dropped
		s_d.int_reset = 1'b0;
		if (wr_aux) begin
			s_d.start = wr_data[AUX_START_BIT];
			s_d.coil_en = wr_data[AUX_COIL_BIT];
			s_d.spindle_en = wr_data[AUX_SPINDLE_BIT];
			s_d.test_en = wr_data[AUX_TEST_BIT];
			s_d.brake_req = wr_data[AUX_BRAKE_BIT];
			s_d.int_reset = wr_data[AUX_SRESET_BIT];
		end

		// register brake: park first, then brake with an internal reset
		case (s_q.brake_fsm)
			MDC_BRK_IDLE: begin
				if (s_q.brake_req) begin
					s_d.brake_fsm = MDC_BRK_PARK;
				end
			end
			MDC_BRK_PARK: begin
				if (!s_q.brake_req) begin
					s_d.brake_fsm = MDC_BRK_IDLE;
				end else if (!s_q.park_busy) begin
					s_d.brake_fsm = MDC_BRK_BRAKE;
					s_d.int_reset = 1'b1;
				end
			end
			MDC_BRK_BRAKE: begin
				if (!s_q.brake_req) begin
					s_d.brake_fsm = MDC_BRK_IDLE;
				end
			end
			default: s_d.brake_fsm = MDC_BRK_IDLE;
		endcase
		// spindle brake output has its own flop, in step with the brake state
		s_d.brake_on = (s_d.brake_fsm == MDC_BRK_BRAKE);

		// internal reset returns controls to defaults; brake request survives it
		// preload pattern and counter are left alone; chop blank returns to its reset value
		if (s_q.int_reset) begin
			s_d.atten_sel = RST_ATTEN;
			s_d.sat_seek = 1'b0;
			s_d.coil_hiz = 1'b0;
			s_d.park_timer_disable = 1'b0;
			s_d.chop_blank_enable = RST_CHOP_BLANK;
			s_d.start = 1'b0;
			s_d.coil_en = 1'b0;
			s_d.spindle_en = 1'b0;
			s_d.test_en = 1'b0;
		end

		// thermal flag is sticky until read; a new event beats the clear
		if (rd_vcc || rd_aux) begin
			s_d.thermal_flag = 1'b0;
		end
		if (s_q.sync2[IN_OVERTEMP]) begin
			s_d.thermal_flag = 1'b1;
		end

		// read path shows live status plus the stored hiz, coil, spindle and test bits
		// every strobe is answered, mapped or not, so a host never waits on a stray address
		s_d.rvalid = rd_en;
		s_d.rdata = 8'h00;
		if (rd_vcc) begin
			s_d.rdata[VCC_THERMAL_BIT] = s_q.thermal_flag;
			s_d.rdata[VCC_PARK_BIT] = s_q.park_busy & ~braking;
			s_d.rdata[VCC_SATSEEK_BIT] = s_q.sync2[IN_SAT_CMP];
			s_d.rdata[VCC_HIZ_BIT] = s_q.coil_hiz;
			s_d.rdata[VCC_LOOPBACK_BIT] = s_q.sync2[IN_LOOPBACK];
		end else if (rd_aux) begin
			s_d.rdata[AUX_COIL_BIT] = s_q.coil_en;
			s_d.rdata[AUX_SPINDLE_BIT] = s_q.spindle_en;
			s_d.rdata[AUX_THERMAL_BIT] = s_q.thermal_flag;
			s_d.rdata[AUX_TEST_BIT] = s_q.test_en;
			s_d.rdata[AUX_BRAKE_BIT] = braking;
		end
	end

	// single register stage for all state
	// synchronous reset, so every flop leaves reset on the same edge
	always_ff @(posedge clock) begin
		if (rst) begin
			s_q <= '0;
			s_q.park_busy <= RST_PARK_REQ;
			s_q.chop_blank_enable <= RST_CHOP_BLANK;
			s_q.brake_fsm <= MDC_BRK_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from the state flops
	// no output is decoded, so none can glitch between edges
	assign rd_data = s_q.rdata;
	assign rd_valid = s_q.rvalid;
	assign atten_active = s_q.atten_out;
	assign coil_enable = s_q.coil_en;
	assign coil_output_hiz = s_q.coil_hiz;
	assign coil_saturate = s_q.sat_seek;
	assign coil_sat_polarity = s_q.sat_pol;
	assign park_active = s_q.park_busy;
	assign phase_high_drive = s_q.hi_drv;
	assign phase_low_drive = s_q.lo_drv;
	assign commutation_counter = s_q.comm_cnt;
	assign commutation_run = s_q.comm_run;
	assign spindle_enable = s_q.spindle_en;
	assign spindle_brake = s_q.brake_on;
	assign pwm_off_suppress = s_q.pwm_supp;
	assign slew_control_off = s_q.start;
	assign single_phase_bemf = s_q.start;
	assign test_unlock = s_q.test_en;
	assign soft_reset = s_q.int_reset;

endmodule : mdc_regs

// ===== tb/mdc_regs_assertions.sv
`timescale 1ns/10ps
// port-level checks on the register bank; only ports of mdc_regs are seen here
module mdc_regs_checker
	import mdc_pkg::*;
#(
	parameter int PARK_DELAY_CYCLES = PARK_CYCLES
) (
	// clock and reset
	input wire logic       clock,
	input wire logic       rst,
	// register port
	input wire logic       wr_en,
	input wire logic       rd_en,
	input wire logic [3:0] addr,
	input wire logic       atten_gate_in,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] rd_data,
	input wire logic       rd_valid,
	// controls
	input wire logic [2:0] atten_active,
	input wire logic       coil_saturate,
	input wire logic       coil_output_hiz,
	input wire logic [2:0] phase_high_drive,
	input wire logic [2:0] phase_low_drive,
	input wire logic       slew_control_off,
	input wire logic       single_phase_bemf,
	input wire logic       soft_reset
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// write decodes, shared by several properties
	wire vc_wr = wr_en && addr == ADDR_VOICE_COIL_CONTROL;
	wire ax_wr = wr_en && addr == ADDR_AUXILIARY_CONTROL;

	rd_answer_a:
		assert property (rd_en |=> rd_valid) else $error("read gave no answer");
	rd_single_a:
		assert property (!rd_en |=> !rd_valid) else $error("stray read answer");
	preload_rd_a:
		assert property (rd_en && addr == ADDR_COMMUTATION_PRELOAD |=> rd_data == 8'h00) else $error("preload read");
	aux_spare_a:
		assert property (rd_en && addr == ADDR_AUXILIARY_CONTROL |=> rd_data[0] == 1'b0 && rd_data[6:5] == 2'h0)
			else $error("aux write-only bits read back");
	atten_gate_a:
		assert property (vc_wr |-> ##2 atten_active == ($past(wr_data[2:0], 2) & {3{$past(atten_gate_in, 2)}}))
			else $error("attenuation not gated");
	sat_seek_a:
		assert property (vc_wr |=> coil_saturate == $past(wr_data[5])) else $error("saturate command wrong");
	coil_hiz_a:
		assert property (vc_wr |=> coil_output_hiz == $past(wr_data[6])) else $error("tristate command wrong");
	start_mode_a:
		assert property (ax_wr |=> slew_control_off == $past(wr_data[0]) && single_phase_bemf == $past(wr_data[0]))
			else $error("start controls wrong");
	no_shoot_a:
		assert property ((phase_high_drive & phase_low_drive) == 3'h0) else $error("high and low drive together");
	sreset_pulse_a:
		assert property (soft_reset |=> !soft_reset) else $error("internal reset not a pulse");
endmodule : mdc_regs_checker

bind mdc_regs mdc_regs_checker #(.PARK_DELAY_CYCLES(PARK_DELAY_CYCLES)) u_mdc_regs_checker (
	.clock(clock), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .atten_gate_in(atten_gate_in),
	.wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid), .atten_active(atten_active),
	.coil_saturate(coil_saturate), .coil_output_hiz(coil_output_hiz), .phase_high_drive(phase_high_drive),
	.phase_low_drive(phase_low_drive), .slew_control_off(slew_control_off),
	.single_phase_bemf(single_phase_bemf), .soft_reset(soft_reset)
);

// ===== tb/mdc_host.sv
`timescale 1ns/10ps
// host firmware stand-in: one strobe access per call, idle cycle between calls
module mdc_host
	import mdc_pkg::*;
(
	// clock
	input  wire logic       clock,
	// read answer
	input  wire logic [7:0] rd_data,
	input  wire logic       rd_valid,
	// access strobes
	output logic            wr_en,
	output logic            rd_en,
	output logic      [3:0] addr,
	output logic            atten_gate_in,
	output logic      [7:0] wr_data
);
	initial {wr_en, rd_en, addr, atten_gate_in, wr_data} = '0;

	task automatic write(input logic [3:0] a, input logic [7:0] d, input logic g);
		@(posedge clock);
		wr_en <= 1'b1;
		addr <= a;
		wr_data <= d;
		atten_gate_in <= g;
		@(posedge clock);
		wr_en <= 1'b0;
		wr_data <= ~d; // released data no longer shows the written value
	endtask : write

	// answer is taken at the edge where rd_valid is high
	task automatic read(input logic [3:0] a, output logic [7:0] d, output logic v);
		@(posedge clock);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd_en <= 1'b0;
		@(posedge clock);
		d = rd_data;
		v = rd_valid;
	endtask : read

	// run entry: park-timer disable cleared first, then all drive enables with chop blank on
	task automatic prep_run();
		write(ADDR_VOICE_COIL_CONTROL, 8'h00, 1'b0);
		write(ADDR_COMMUTATION_PRELOAD, 8'h7F, 1'b0);
	endtask : prep_run
endmodule : mdc_host

// ===== tb/mdc_regs_test.sv
`timescale 1ns/10ps
// register bank bench: host model drives the strobe port, analog pins driven here
module mdc_regs_test;
	import mdc_pkg::*;
	localparam logic [3:0] VC = ADDR_VOICE_COIL_CONTROL;
	localparam logic [3:0] CP = ADDR_COMMUTATION_PRELOAD;
	localparam logic [3:0] AX = ADDR_AUXILIARY_CONTROL;
	logic       clock = 1'b0;
	logic       rst = 1'b1;
	logic       sat_comparator = 1'b0, coil_loopback = 1'b0, over_temperature_flag = 1'b0, dac_sign = 1'b0;
	logic       bemf_blank_cmp = 1'b0, phase_a_neg_crossing = 1'b0, spindle_clock_in = 1'b0;
	logic       wr_en, rd_en, atten_gate_in, rd_valid, coil_enable, coil_output_hiz, coil_saturate;
	logic [3:0] addr;
	logic [7:0] wr_data, rd_data;
	logic [2:0] atten_active, phase_high_drive, phase_low_drive, commutation_counter;
	logic       coil_sat_polarity, park_active, commutation_run, spindle_enable, spindle_brake;
	logic       pwm_off_suppress, slew_control_off, single_phase_bemf, test_unlock, soft_reset;
	int         err_total = 0, check_count = 0, cycles = 0;

	always #4 clock = ~clock;

	// short park delay keeps the run brief
	mdc_regs #(.PARK_DELAY_CYCLES(8)) u_mdc_regs (
		.clock(clock), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .atten_gate_in(atten_gate_in),
		.wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid), .sat_comparator(sat_comparator),
		.coil_loopback(coil_loopback), .over_temperature_flag(over_temperature_flag), .dac_sign(dac_sign),
		.bemf_blank_cmp(bemf_blank_cmp), .phase_a_neg_crossing(phase_a_neg_crossing),
		.spindle_clock_in(spindle_clock_in), .atten_active(atten_active), .coil_enable(coil_enable),
		.coil_output_hiz(coil_output_hiz), .coil_saturate(coil_saturate), .coil_sat_polarity(coil_sat_polarity),
		.park_active(park_active), .phase_high_drive(phase_high_drive), .phase_low_drive(phase_low_drive),
		.commutation_counter(commutation_counter), .commutation_run(commutation_run),
		.spindle_enable(spindle_enable), .spindle_brake(spindle_brake), .pwm_off_suppress(pwm_off_suppress),
		.slew_control_off(slew_control_off), .single_phase_bemf(single_phase_bemf),
		.test_unlock(test_unlock), .soft_reset(soft_reset)
	);
	mdc_host u_host (
		.clock(clock), .rd_data(rd_data), .rd_valid(rd_valid), .wr_en(wr_en), .rd_en(rd_en),
		.addr(addr), .atten_gate_in(atten_gate_in), .wr_data(wr_data)
	);

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick

	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic       v;
		u_host.read(a, d, v);
		chk(8'(v), 8'h01);
		chk(d, exp);
	endtask : rd

	// spindle clock pulse long enough for the two-flop synchroniser and the drive interlock
	task automatic spin();
		spindle_clock_in <= 1'b1;
		tick(4);
		spindle_clock_in <= 1'b0;
		tick(4);
	endtask : spin

	task automatic results();
		$display("checks %0d, mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results

	// hang guard: the sequence needs well under this many cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			$display("Error at %0t: timeout", $time);
			results();
		end
	end

	initial begin
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		chk(8'({park_active, commutation_run, spindle_brake, coil_enable}), 8'h08);
		tick(12);
		chk(8'(park_active), 8'h00);
		rd(VC, 8'h00);
		u_host.write(VC, 8'h10, 1'b0);
		tick(2);
		rd(VC, 8'h10);
		tick(4);
		u_host.write(VC, 8'h10, 1'b0);
		u_host.write(VC, 8'h80, 1'b0);
		tick(2);
		chk(8'(park_active), 8'h00);
		for (int i = 0; i < 3; i++) begin
			u_host.write(VC, 8'(1 << i), 1'b1);
			tick(3);
			chk(8'(atten_active), 8'(1 << i));
		end
		u_host.write(VC, 8'h07, 1'b0);
		tick(3);
		chk(8'(atten_active), 8'h00);
		dac_sign <= 1'b1;
		sat_comparator <= 1'b1;
		coil_loopback <= 1'b1;
		u_host.write(VC, 8'h60, 1'b0);
		tick(3);
		chk(8'({coil_saturate, coil_sat_polarity, coil_output_hiz}), 8'h07);
		u_host.write(VC, 8'h00, 1'b0);
		tick(3);
		rd(VC, 8'hA0);
		{sat_comparator, coil_loopback, over_temperature_flag} <= 3'b001;
		tick(4);
		over_temperature_flag <= 1'b0;
		tick(3);
		rd(AX, 8'h08);
		rd(AX, 8'h00);
		u_host.write(AX, 8'h17, 1'b0);
		tick(2);
		chk(8'({slew_control_off, single_phase_bemf, coil_enable, spindle_enable, test_unlock}), 8'h1F);
		rd(AX, 8'h16);
		u_host.write(AX, 8'h04, 1'b0);
		u_host.write(CP, 8'h09, 1'b0);
		tick(4);
		chk(8'(phase_high_drive), 8'h00);
		spin();
		chk(8'({phase_high_drive, phase_low_drive}), 8'h08);
		u_host.write(CP, 8'h02, 1'b0);
		spin();
		chk(8'({phase_high_drive, phase_low_drive}), 8'h02);
		{bemf_blank_cmp, phase_a_neg_crossing} <= 2'b11;
		tick(4);
		chk(8'(pwm_off_suppress), 8'h00);
		u_host.write(CP, 8'h42, 1'b0);
		tick(3);
		chk(8'(pwm_off_suppress), 8'h01);
		u_host.prep_run();
		spin();
		chk(8'(commutation_run), 8'h01);
		spin();
		chk(8'(commutation_counter), 8'h01);
		u_host.write(CP, 8'h5F, 1'b0);
		spin();
		chk(8'({commutation_run, commutation_counter}), 8'h00);
		rd(CP, 8'h00);
		u_host.write(AX, 8'h80, 1'b0);
		rd(VC, 8'h00);
		tick(30);
		chk(8'({spindle_brake, phase_high_drive, phase_low_drive}), 8'h47);
		rd(AX, 8'h80);
		u_host.write(AX, 8'h00, 1'b0);
		tick(3);
		chk(8'(spindle_brake), 8'h00);
		u_host.write(AX, 8'h22, 1'b0);
		tick(1);
		chk(8'({soft_reset, coil_enable}), 8'h03);
		tick(1);
		chk(8'({soft_reset, coil_enable}), 8'h00);
		rd(4'h5, 8'h00);
		results();
	end
endmodule : mdc_regs_test
